// ===== cgr_pkg.sv
// Package for the general-control register bank of the clock generator
package cgr_pkg;

  localparam int REG_AW = 6;
  localparam int REG_DW = 16;

  // Register offsets (word addresses on the serial register port)
  localparam logic [5:0] OFF_GENERAL_CONTROL = 6'h00;
  localparam logic [5:0] OFF_OUT2_RESERVED_A = 6'h29;
  localparam logic [5:0] OFF_OUT2_RESERVED_B = 6'h2a;
  localparam logic [5:0] OFF_OUT2_DIVIDER_MUX = 6'h2b;
  localparam logic [5:0] OFF_OUT2_SYNC_DELAY_BUFFER = 6'h2c;
  localparam logic [5:0] OFF_OUT2_GLITCHLESS_SPREAD = 6'h2d;
  localparam logic [5:0] OFF_OUT2_RESERVED_C = 6'h2e;
  localparam logic [5:0] OFF_OUT3_RESERVED_A = 6'h2f;
  localparam logic [5:0] OFF_OUT3_RESERVED_B = 6'h30;
  localparam logic [5:0] OFF_OUT3_DIVIDER_MUX = 6'h31;
  localparam logic [5:0] OFF_OUT3_SYNC_DELAY_BUFFER = 6'h32;
  localparam logic [5:0] OFF_OUT3_GLITCHLESS_SPREAD = 6'h33;
  localparam logic [5:0] OFF_OUT3_RESERVED_C = 6'h34;
  localparam logic [5:0] OFF_OUT4_RESERVED_A = 6'h35;
  localparam logic [5:0] OFF_OUT4_RESERVED_B = 6'h36;
  localparam logic [5:0] OFF_OUT4_DIVIDER_MUX = 6'h37;
  localparam logic [5:0] OFF_OUT4_SYNC_DELAY_BUFFER = 6'h38;
  localparam logic [5:0] OFF_OUT4_GLITCHLESS_SPREAD = 6'h39;
  localparam logic [5:0] OFF_OUT4_RESERVED_C = 6'h3a;
  localparam logic [5:0] OFF_ALL_OUTPUTS_DISTRIBUTION_BYPASS = 6'h3b;
  localparam logic [5:0] OFF_ALL_OUTPUTS_RESERVED_A = 6'h3c;
  localparam logic [5:0] OFF_ALL_OUTPUTS_RESERVED_D = 6'h3f;

  // Channel bank spans 0x29..0x3f
  localparam logic [5:0] OFF_CHAN_FIRST = OFF_OUT2_RESERVED_A;
  localparam logic [5:0] OFF_CHAN_LAST = OFF_ALL_OUTPUTS_RESERVED_D;
  localparam int CHAN_WORDS = 23;

  // General control field positions
  localparam int BIT_SLAVE_ADDRESS_LSB = 15;
  localparam int BIT_PIN_ZERO_FUNCTION_SELECT = 14;
  localparam int BIT_PIN_FOUR_DIRECTION = 13;
  localparam int BIT_PIN_ONE_DIRECTION = 12;
  localparam int BIT_PIN_ZERO_DIRECTION = 11;
  localparam int BIT_ZERO_DELAY_CLOCK_SELECT = 10;
  localparam int BIT_RESERVED_HI = 9;
  localparam int BIT_ZERO_DELAY_ENABLE = 8;
  localparam int BIT_RESERVED_LO = 7;
  localparam int BIT_LOCK_DETECT_RESET = 6;
  localparam int BIT_SYNC_PULSE = 5;
  localparam int BIT_RECALIBRATE = 4;
  localparam int BIT_SOFT_RESET_KIND = 3;
  localparam int BIT_SOFT_RESET = 2;
  localparam int BIT_POWER_DOWN = 1;
  localparam int BIT_PIN_MODE = 0;

  localparam logic [15:0] GENERAL_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CHAN_RESET = 16'h0000;
  // Self-clearing positions never hold a 1
  localparam logic [15:0] SELF_CLEAR_MASK = 16'h0034;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } cgr_req_t;

  // EEPROM engine handshake for the slave address LSB
  typedef struct packed {
    logic commit;
    logic load;
    logic loaded_lsb;
  } cgr_eeprom_t;

  // Decoded controls to the analog and pin logic
  typedef struct packed {
    logic pin_zero_is_sync;
    logic pin_four_output;
    logic pin_one_output;
    logic pin_zero_output;
    logic zero_delay_enable;
    logic external_feedback;
    logic lock_detect_reset;
    logic soft_reset_kind;
    logic power_down;
    logic pin_mode;
  } cgr_ctrl_t;

endpackage

// ===== cgr_general_control.sv
// General-control register bank with channel register storage
// Functional notes
// [R1] Commit stores bit 15 as address LSB; page load restores it into bit 15.
// [R2] Bit 14 chooses pin zero input: 0 reset input, 1 divider sync input.
// [R3] Bits 13, 12, 11 set directions of pins four, one, zero; 1 is output.
// [R4] Bit 8 enables zero-delay; bit 10 picks external feedback only then.
// [R5] Bit 6 holds the lock detector in reset while set.
// [R6] Writing 1 to bit 5 gives one sync pulse; writing 0 does nothing.
// [R7] Writing 1 to bit 4 restarts calibration from current codes.
// [R8] General control resets to zero; reserved bits 9 and 7 stay writable.
// [R9] Writing 1 to bit 2 gives one soft reset pulse; 0 does nothing.
// [R10] Bit 0 selects serial control (0) or pin output-enable mode (1).
// [R11] Self-clearing bits always read back as zero.
module cgr_general_control
  import cgr_pkg::*;
#(
  parameter int CHAN_N = cgr_pkg::CHAN_WORDS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire cgr_pkg::cgr_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  input wire cgr_pkg::cgr_eeprom_t eeprom,
  output logic slave_address_lsb,
  output cgr_pkg::cgr_ctrl_t ctrl,
  output logic sync_pulse,
  output logic recal_pulse,
  output logic soft_reset_pulse,
  output logic [15:0] chan_word [CHAN_N]
);
  import cgr_pkg::*;

  logic [15:0] gen;
  logic [15:0] next_gen;
  logic [15:0] chan [CHAN_N];
  logic [15:0] next_chan [CHAN_N];
  logic addr_lsb;
  logic next_addr_lsb;
  logic next_sync_pulse;
  logic next_recal_pulse;
  logic next_soft_reset_pulse;
  logic [15:0] next_rdata;
  logic next_rvalid;

  function automatic logic in_chan(input logic [5:0] a);
    return (a >= OFF_CHAN_FIRST) && (a <= OFF_CHAN_LAST);
  endfunction

  function automatic int chan_index(input logic [5:0] a);
    return int'(a - OFF_CHAN_FIRST);
  endfunction

  logic gen_wr;
  assign gen_wr = req.wr && (req.addr == OFF_GENERAL_CONTROL);

  always_comb begin
    next_gen = gen;
    next_addr_lsb = addr_lsb;
    next_chan = chan;
    if (gen_wr) begin
      // Pulse bits are never stored
      next_gen = req.wdata & ~SELF_CLEAR_MASK; // [R11] [R8]
    end
    if (eeprom.commit) begin
      next_addr_lsb = next_gen[BIT_SLAVE_ADDRESS_LSB]; // [R1]
    end
    if (eeprom.load) begin
      // Load overrides a same-cycle host write of bit 15
      next_gen[BIT_SLAVE_ADDRESS_LSB] = eeprom.loaded_lsb; // [R1]
      next_addr_lsb = eeprom.loaded_lsb; // [R1]
    end
    if (req.wr && in_chan(req.addr)) begin
      next_chan[chan_index(req.addr)] = req.wdata;
    end
  end

  always_comb begin
    next_sync_pulse = gen_wr && req.wdata[BIT_SYNC_PULSE]; // [R6]
    next_recal_pulse = gen_wr && req.wdata[BIT_RECALIBRATE]; // [R7]
    next_soft_reset_pulse = gen_wr && req.wdata[BIT_SOFT_RESET]; // [R9]
  end

  always_comb begin
    next_rvalid = req.rd;
    next_rdata = 16'h0000;
    if (req.rd) begin
      if (req.addr == OFF_GENERAL_CONTROL) begin
        next_rdata = gen; // [R11]
      end else if (in_chan(req.addr)) begin
        next_rdata = chan[chan_index(req.addr)];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen <= GENERAL_CONTROL_RESET; // [R8]
      addr_lsb <= 1'b0;
      for (int i = 0; i < CHAN_N; i++) begin
        chan[i] <= CHAN_RESET;
      end
      sync_pulse <= 1'b0;
      recal_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      gen <= next_gen;
      addr_lsb <= next_addr_lsb;
      chan <= next_chan;
      sync_pulse <= next_sync_pulse;
      recal_pulse <= next_recal_pulse;
      soft_reset_pulse <= next_soft_reset_pulse;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign slave_address_lsb = addr_lsb;
  assign chan_word = chan;

  always_comb begin
    ctrl.pin_zero_is_sync = gen[BIT_PIN_ZERO_FUNCTION_SELECT]; // [R2]
    ctrl.pin_four_output = gen[BIT_PIN_FOUR_DIRECTION]; // [R3]
    ctrl.pin_one_output = gen[BIT_PIN_ONE_DIRECTION]; // [R3]
    ctrl.pin_zero_output = gen[BIT_PIN_ZERO_DIRECTION]; // [R3]
    ctrl.zero_delay_enable = gen[BIT_ZERO_DELAY_ENABLE]; // [R4]
    ctrl.external_feedback = gen[BIT_ZERO_DELAY_ENABLE]
      & gen[BIT_ZERO_DELAY_CLOCK_SELECT]; // [R4]
    ctrl.lock_detect_reset = gen[BIT_LOCK_DETECT_RESET]; // [R5]
    ctrl.soft_reset_kind = gen[BIT_SOFT_RESET_KIND];
    ctrl.power_down = gen[BIT_POWER_DOWN];
    ctrl.pin_mode = gen[BIT_PIN_MODE]; // [R10]
  end

endmodule

// ===== cgr_general_control_assertions.sv
// Checker for the general-control register bank
module cgr_general_control_assertions
  import cgr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire cgr_pkg::cgr_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire cgr_pkg::cgr_eeprom_t eeprom,
  input wire logic slave_address_lsb,
  input wire cgr_pkg::cgr_ctrl_t ctrl,
  input wire logic sync_pulse,
  input wire logic recal_pulse,
  input wire logic soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic w0;
  assign w0 = req.wr && req.addr == 6'h00;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_sync;
    w0 && req.wdata[5] |=> sync_pulse;
  endproperty
  property p_nosync;
    !(w0 && req.wdata[5]) |=> !sync_pulse;
  endproperty
  property p_recal;
    w0 && req.wdata[4] |=> recal_pulse
      ##1 (recal_pulse == $past(w0 && req.wdata[4]));
  endproperty
  property p_srst;
    soft_reset_pulse |-> $past(w0 && req.wdata[2]);
  endproperty
  property p_rd;
    req.rd && req.addr == 6'h00 |=> rvalid && (rdata & 16'h0034) == 16'h0;
  endproperty
  property p_zdm;
    w0 |=> ctrl.external_feedback == $past(req.wdata[8] & req.wdata[10]);
  endproperty
  property p_dir;
    w0 |=> {ctrl.pin_four_output, ctrl.pin_one_output,
      ctrl.pin_zero_output} == $past(req.wdata[13:11]);
  endproperty
  property p_ld;
    eeprom.load |=> slave_address_lsb == $past(eeprom.loaded_lsb);
  endproperty
  a_sync: assert property (p_sync) else $error("no sync pulse");
  a_nosync: assert property (p_nosync) else $error("stray sync");
  a_recal: assert property (p_recal) else $error("bad recal");
  a_srst: assert property (p_srst) else $error("stray reset");
  a_rd: assert property (p_rd) else $error("bad read");
  a_zdm: assert property (p_zdm) else $error("bad feedback");
  a_dir: assert property (p_dir) else $error("bad direction");
  a_ld: assert property (p_ld) else $error("bad load");
  c_sync: cover property (sync_pulse ##1 !sync_pulse);
  c_rd: cover property (rvalid);
  c_ld: cover property (eeprom.load);
endmodule

// ===== cgr_host_model.sv
// Register host issuing single-cycle strobes
module cgr_host_model
  import cgr_pkg::*;
(
  input wire logic clk,
  output cgr_pkg::cgr_req_t req,
  input wire logic rvalid,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d,
    output bit ok);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    req.addr = ~a;
    ok = rvalid === 1'b1;
    d = rdata;
  endtask
endmodule

// ===== cgr_general_control_test.sv
// Self-checking bench for the general-control register bank
module cgr_general_control_test;
  import cgr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cgr_req_t req;
  cgr_eeprom_t ee = '0;
  cgr_ctrl_t ctrl;
  logic [15:0] rdata;
  logic [15:0] cw [CHAN_WORDS];
  logic rvalid, lsb, sp, rp, srp;
  int n_fail = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  cgr_host_model i_cgr_host_model (.clk(clk), .req(req), .rvalid(rvalid),
    .rdata(rdata));
  cgr_general_control i_cgr_general_control (.clk(clk), .nrst(nrst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .eeprom(ee),
    .slave_address_lsb(lsb), .ctrl(ctrl), .sync_pulse(sp),
    .recal_pulse(rp), .soft_reset_pulse(srp), .chan_word(cw));
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic rc(logic [5:0] a, logic [15:0] e);
    logic [15:0] d;
    bit ok;
    i_cgr_host_model.rd(a, d, ok);
    if (!ok) begin
      n_fail++;
      results();
    end
    chk("rdata", e, d);
  endtask
  task automatic ep(logic c, logic l);
    @(negedge clk);
    ee = '{commit: c, load: l, loaded_lsb: 1'b0};
    @(negedge clk);
    ee = '0;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rc(6'h00, 16'h0000);
    $display("test reset done");
    i_cgr_host_model.wr(6'h00, 16'hffff);
    chk("pulses", 16'h0007, {13'h0, sp, rp, srp});
    chk("ctrl", 16'h03ff, {6'h00, ctrl});
    rc(6'h00, 16'hffcb);
    i_cgr_host_model.wr(6'h00, 16'h0400);
    chk("pulses", 16'h0000, {13'h0, sp, rp, srp});
    chk("ctrl", 16'h0000, {6'h00, ctrl});
    rc(6'h00, 16'h0400);
    $display("test fields done");
    i_cgr_host_model.wr(6'h00, 16'h8000);
    ep(1'b1, 1'b0);
    chk("lsb", 16'h0001, {15'h0, lsb});
    ep(1'b0, 1'b1);
    chk("lsb", 16'h0000, {15'h0, lsb});
    rc(6'h00, 16'h0000);
    $display("test eeprom done");
    i_cgr_host_model.wr(6'h3b, 16'h1234);
    i_cgr_host_model.wr(6'h05, 16'hbeef);
    chk("chan", 16'h1234, cw[18]);
    rc(6'h05, 16'h0000);
    $display("test banks done");
    results();
  end
endmodule
bind cgr_general_control cgr_general_control_assertions
  i_cgr_general_control_assertions (.clk(clk), .nrst(nrst), .req(req),
  .rdata(rdata), .rvalid(rvalid), .eeprom(eeprom),
  .slave_address_lsb(slave_address_lsb), .ctrl(ctrl),
  .sync_pulse(sync_pulse), .recal_pulse(recal_pulse),
  .soft_reset_pulse(soft_reset_pulse));
